// [verilog/hslc_consts.svh]
/*
 Offsets, field positions, reset values and timing counts of the haptic loop control block.
 Assumes a 50 MHz system clock and 32-bit classic Wishbone register access.
*/
`ifndef HSLC_CONSTS_SVH
`define HSLC_CONSTS_SVH
`define HSLC_CLK_PERIOD_NS 20
`define HSLC_OL_UNIT_NS 98490
`define HSLC_CAL_BASE_UNITS 8'h40
`define HSLC_IDX_STATUS 8'h00
`define HSLC_IDX_COMMAND 8'h0C
`define HSLC_IDX_CAL_COMP 8'h18
`define HSLC_IDX_CAL_EMF 8'h19
`define HSLC_IDX_FEEDBACK 8'h1A
`define HSLC_IDX_LOOP_CTRL 8'h1B
`define HSLC_IDX_LEVEL 8'h1C
`define HSLC_IDX_CTRL4 8'h1F
`define HSLC_IDX_OL_PERIOD 8'h20
`define HSLC_IDX_RES_PERIOD 8'h22
`define HSLC_FB_ACT_TYPE 7
`define HSLC_FB_BRAKE_LSB 4
`define HSLC_FB_LOOP_GAIN_LSB 2
`define HSLC_FB_EMF_GAIN_LSB 0
`define HSLC_LC_STARTUP_BOOST 0
`define HSLC_LC_BRAKE_STAB 1
`define HSLC_LC_DOUBLE_SAMPLE 2
`define HSLC_LC_OL_FORCE 3
`define HSLC_LC_PWM_SOURCE 4
`define HSLC_LC_ZC_TIME_LSB 5
`define HSLC_LC_SAMPLE_TIME_LSB 8
`define HSLC_LC_DRIVE_TIME_LSB 10
`define HSLC_LC_CAL_TIME_LSB 15
`define HSLC_C4_AUTO_OL 5
`define HSLC_C4_FALLBACK_LSB 2
`define HSLC_FEEDBACK_RST 8'h36
`define HSLC_LOOP_CTRL_RST 17'h05022
`define HSLC_LEVEL_RST 16'hFF3E
`define HSLC_CTRL4_RST 8'h00
`define HSLC_OL_PERIOD_RST 7'h33
`define HSLC_BOOST_HALVES 4'h4
`define HSLC_IMP_OPEN 8'hF0
`define HSLC_IMP_SHORT 8'h04
`endif

// [verilog/hslc_pkg.sv]
/*
 Types of the haptic loop control block.
 Assumes the constants header is compiled alongside.
*/
package hslc_pkg;
    typedef enum logic [1:0] {
        LOOP_IDLE, LOOP_SYNC, LOOP_OPEN, LOOP_LATCHED
    } hslc_loop_type;
    typedef enum logic [1:0] {
        CAL_IDLE, CAL_RUN, CAL_DIAG
    } hslc_cal_type;
endpackage

// [verilog/hslc_loop_ctrl.sv]
/*
 Haptic smart-loop control: resonance tracking, open-loop fallback, gains, calibration, diagnostics.
 Assumes back-EMF zero-cross, validity and polarity come from the analog front end as asynchronous pins,
 impedance and back-EMF magnitude codes are stable during calibration, and a classic Wishbone master.
*/
// The implementer's own choices: the Wishbone slave port and the register offsets.
`include "hslc_consts.svh"

// How it works
// - Linear mode locks on the first half cycle and tracks every back-EMF zero cross.
// - Measured resonance period is readable and updated on every zero cross while in the sync state.
// - Invalid back-EMF keeps driving open-loop at drive time minus detect time per half.
// - Auto open-loop enable latches open-loop after sync failure, with no resync.
// - Two-bit count sets tolerated non-synchronized half cycles before that latch.
// - Latched open-loop period is the seven-bit value times 98.49 us, no overdrive or brake.
// - Startup boost raises loop gain for the first half cycles of a waveform.
// - Three-bit brake factor multiplies the gain while braking.
// - Brake stabilizer halves the gain as braking nears completion.
// - Full-scale input gives rated level, one less for rated above 128; overdrive and brake clamp at the clamp setting.
// - A failed level calibration sets the diagnostic fail flag.
// - Calibration stores the resistive-loss factor and the back-EMF normalization factor.
// - Two-bit calibration time sets calibration duration.
// - Two-bit loop gain sets the controller gain.
// - Calibration writes the amplifier gain; longer sample time raises effective gain.
// - Back-EMF sampled once per period, twice when double sampling is selected.
// - Diagnostics flag an open or shorted actuator.
// - Waveform start follows actuator motion if moving, else default direction.
// - PWM-sourced open-loop commutates at input PWM frequency over 128.
// - Digital open-loop uses the open-loop period register from the internal time base.
module hslc_loop_ctrl
    import hslc_pkg::*;
#(
    parameter int OL_HALF_CYC = `HSLC_OL_UNIT_NS / (2 * `HSLC_CLK_PERIOD_NS)
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic emf_zero_cross_i,
    input wire logic emf_valid_i,
    input wire logic emf_polarity_i,
    input wire logic pwm_in_i,
    input wire logic brake_i,
    input wire logic [7:0] input_level_i,
    input wire logic [7:0] impedance_code_i,
    input wire logic [7:0] emf_magnitude_i,
    output logic drive_polarity_o,
    output logic [7:0] drive_level_o,
    output logic [7:0] loop_gain_o,
    output logic [2:0] emf_gain_eff_o,
    output logic emf_sample_o,
    output logic open_loop_o
);
    // Two-stage synchronizers for the asynchronous pins
    logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q;
    logic [3:0] pin_raw;
    assign pin_raw = {pwm_in_i, emf_polarity_i, emf_valid_i, emf_zero_cross_i};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    pin_s1_q[gi] <= 1'b0;
                    pin_s2_q[gi] <= 1'b0;
                    pin_s3_q[gi] <= 1'b0;
                end else begin
                    pin_s1_q[gi] <= pin_raw[gi];
                    pin_s2_q[gi] <= pin_s1_q[gi];
                    pin_s3_q[gi] <= pin_s2_q[gi];
                end
            end
        end
    endgenerate
    logic zc_evt, emf_ok, emf_pol, pwm_rise;
    assign zc_evt = pin_s2_q[0] ^ pin_s3_q[0];
    assign emf_ok = pin_s2_q[1];
    assign emf_pol = pin_s2_q[2];
    assign pwm_rise = pin_s2_q[3] & ~pin_s3_q[3];

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] idx);
        return adr == idx;
    endfunction

    // Register file
    logic [7:0] feedback_q, feedback_d, ctrl4_q, ctrl4_d, cal_comp_q, cal_comp_d, cal_emf_q, cal_emf_d;
    logic [16:0] loop_ctrl_q, loop_ctrl_d;
    logic [15:0] level_q, level_d;
    logic [6:0] ol_period_q, ol_period_d;
    logic play_q, play_d, diag_fail_q, diag_fail_d;
    logic [1:0] cmd_start;
    logic ack_d, wr_stb;
    logic [31:0] rdat_d, wb_dat_q;
    hslc_cal_type cal_q, cal_d;
    hslc_loop_type loop_q, loop_d;
    logic [7:0] res_period_q, res_period_d;
    logic [9:0] cal_cnt_q, cal_cnt_d;
    logic half_tick;

    assign ack_d = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_stb = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign cmd_start = (wr_stb && hit(wb_adr_i, `HSLC_IDX_COMMAND)) ? wb_dat_i[2:1] : 2'b00;

    always_comb begin
        feedback_d = feedback_q;
        loop_ctrl_d = loop_ctrl_q;
        level_d = level_q;
        ctrl4_d = ctrl4_q;
        ol_period_d = ol_period_q;
        play_d = play_q;
        rdat_d = 32'h00000000;
        if (wr_stb) begin
            if (hit(wb_adr_i, `HSLC_IDX_FEEDBACK)) feedback_d = wb_dat_i[7:0];
            if (hit(wb_adr_i, `HSLC_IDX_LOOP_CTRL)) begin
                loop_ctrl_d[7:0] = wb_dat_i[7:0];
                if (wb_sel_i[1]) loop_ctrl_d[15:8] = wb_dat_i[15:8];
                if (wb_sel_i[2]) loop_ctrl_d[16] = wb_dat_i[16];
            end
            if (hit(wb_adr_i, `HSLC_IDX_LEVEL)) begin
                level_d[7:0] = wb_dat_i[7:0];
                if (wb_sel_i[1]) level_d[15:8] = wb_dat_i[15:8];
            end
            if (hit(wb_adr_i, `HSLC_IDX_CTRL4)) ctrl4_d = wb_dat_i[7:0];
            if (hit(wb_adr_i, `HSLC_IDX_OL_PERIOD)) ol_period_d = wb_dat_i[6:0];
            if (hit(wb_adr_i, `HSLC_IDX_COMMAND)) play_d = wb_dat_i[0];
        end
        // Calibration writes the amplifier gain it found
        if (cal_q == CAL_RUN && cal_d == CAL_IDLE) begin
            feedback_d[`HSLC_FB_EMF_GAIN_LSB+:2] = emf_magnitude_i[7:6] ^ 2'b11;
        end
        if (ack_d && !wb_we_i) begin
            unique case (1'b1)
                hit(wb_adr_i, `HSLC_IDX_STATUS):
                    rdat_d = {26'h0000000, open_loop_o, cal_q != CAL_IDLE, loop_q, 1'b0, diag_fail_q};
                hit(wb_adr_i, `HSLC_IDX_COMMAND): rdat_d = {29'h00000000, cal_q == CAL_DIAG, cal_q == CAL_RUN, play_q};
                hit(wb_adr_i, `HSLC_IDX_CAL_COMP): rdat_d = {24'h000000, cal_comp_q};
                hit(wb_adr_i, `HSLC_IDX_CAL_EMF): rdat_d = {24'h000000, cal_emf_q};
                hit(wb_adr_i, `HSLC_IDX_FEEDBACK): rdat_d = {24'h000000, feedback_q};
                hit(wb_adr_i, `HSLC_IDX_LOOP_CTRL): rdat_d = {15'h0000, loop_ctrl_q};
                hit(wb_adr_i, `HSLC_IDX_LEVEL): rdat_d = {16'h0000, level_q};
                hit(wb_adr_i, `HSLC_IDX_CTRL4): rdat_d = {24'h000000, ctrl4_q};
                hit(wb_adr_i, `HSLC_IDX_OL_PERIOD): rdat_d = {25'h0000000, ol_period_q};
                hit(wb_adr_i, `HSLC_IDX_RES_PERIOD): rdat_d = {24'h000000, res_period_q};
                default: rdat_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            feedback_q <= `HSLC_FEEDBACK_RST;
            loop_ctrl_q <= `HSLC_LOOP_CTRL_RST;
            level_q <= `HSLC_LEVEL_RST;
            ctrl4_q <= `HSLC_CTRL4_RST;
            ol_period_q <= `HSLC_OL_PERIOD_RST;
            play_q <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_q <= 32'h00000000;
        end else begin
            feedback_q <= feedback_d;
            loop_ctrl_q <= loop_ctrl_d;
            level_q <= level_d;
            ctrl4_q <= ctrl4_d;
            ol_period_q <= ol_period_d;
            play_q <= play_d;
            wb_ack_o <= ack_d;
            wb_dat_q <= rdat_d;
        end
    end
    assign wb_dat_o = wb_dat_q;

    // Field views
    logic is_lra, boost_en, stab_en, dbl_sample, ol_force, pwm_src, auto_ol;
    logic [2:0] brake_ratio;
    logic [1:0] loop_gain, zc_time, sample_time, cal_time, fallback_cnt;
    logic [4:0] drive_time;
    logic [7:0] rated, od_clamp;
    assign is_lra = feedback_q[`HSLC_FB_ACT_TYPE];
    assign brake_ratio = feedback_q[`HSLC_FB_BRAKE_LSB+:3];
    assign loop_gain = feedback_q[`HSLC_FB_LOOP_GAIN_LSB+:2];
    assign boost_en = loop_ctrl_q[`HSLC_LC_STARTUP_BOOST];
    assign stab_en = loop_ctrl_q[`HSLC_LC_BRAKE_STAB];
    assign dbl_sample = loop_ctrl_q[`HSLC_LC_DOUBLE_SAMPLE];
    assign ol_force = loop_ctrl_q[`HSLC_LC_OL_FORCE];
    assign pwm_src = loop_ctrl_q[`HSLC_LC_PWM_SOURCE];
    assign zc_time = loop_ctrl_q[`HSLC_LC_ZC_TIME_LSB+:2];
    assign sample_time = loop_ctrl_q[`HSLC_LC_SAMPLE_TIME_LSB+:2];
    assign drive_time = loop_ctrl_q[`HSLC_LC_DRIVE_TIME_LSB+:5];
    assign cal_time = loop_ctrl_q[`HSLC_LC_CAL_TIME_LSB+:2];
    assign rated = level_q[7:0];
    assign od_clamp = level_q[15:8];
    assign auto_ol = ctrl4_q[`HSLC_C4_AUTO_OL];
    assign fallback_cnt = ctrl4_q[`HSLC_C4_FALLBACK_LSB+:2];

    // Half-unit time base: all loop timers except the PWM-sourced divider count 49.245 us steps
    logic [12:0] tick_cnt_q, tick_cnt_d;
    always_comb begin
        half_tick = tick_cnt_q == 13'(OL_HALF_CYC - 1);
        tick_cnt_d = half_tick ? 13'h0000 : tick_cnt_q + 13'h0001;
    end
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) tick_cnt_q <= 13'h0000;
        else tick_cnt_q <= tick_cnt_d;
    end

    // Resonance loop
    logic [7:0] half_cnt_q, half_cnt_d, fb_half;
    logic [1:0] miss_q, miss_d;
    logic [5:0] pwm_div_q, pwm_div_d;
    logic [3:0] boost_q, boost_d;
    logic pol_q, pol_d, play_prev_q, flip, sample_d, sample_q;
    assign fb_half = (drive_time > {3'b000, zc_time}) ? {3'b000, drive_time - {3'b000, zc_time}} : 8'h01;

    always_comb begin
        loop_d = loop_q;
        half_cnt_d = half_cnt_q;
        miss_d = miss_q;
        pwm_div_d = pwm_div_q;
        boost_d = boost_q;
        res_period_d = res_period_q;
        flip = 1'b0;
        if (!play_q || !is_lra) begin
            loop_d = LOOP_IDLE;
            half_cnt_d = 8'h00;
            miss_d = 2'b00;
        end else if (!play_prev_q) begin
            loop_d = ol_force ? LOOP_LATCHED : LOOP_SYNC;
            half_cnt_d = 8'h00;
            boost_d = `HSLC_BOOST_HALVES;
        end else begin
            unique case (loop_q)
                LOOP_SYNC: begin
                    if (zc_evt) begin
                        res_period_d = half_cnt_q + {7'h00, half_tick};
                        half_cnt_d = 8'h00;
                        miss_d = 2'b00;
                        flip = 1'b1;
                        if (boost_q != 4'h0) boost_d = boost_q - 4'h1;
                    end else if (half_tick) begin
                        half_cnt_d = half_cnt_q + 8'h01;
                        if (half_cnt_d >= fb_half) begin
                            half_cnt_d = 8'h00;
                            flip = 1'b1;
                            if (auto_ol && miss_q == fallback_cnt) loop_d = LOOP_LATCHED;
                            else if (!emf_ok) loop_d = LOOP_OPEN;
                            else miss_d = miss_q + 2'b01;
                        end
                    end
                end
                LOOP_OPEN: begin
                    if (zc_evt && emf_ok) begin
                        loop_d = LOOP_SYNC;
                        half_cnt_d = 8'h00;
                        flip = 1'b1;
                    end else if (half_tick) begin
                        half_cnt_d = half_cnt_q + 8'h01;
                        if (half_cnt_d >= fb_half) begin
                            half_cnt_d = 8'h00;
                            flip = 1'b1;
                        end
                    end
                end
                LOOP_LATCHED: begin
                    if (ol_force && pwm_src) begin
                        if (pwm_rise) begin
                            pwm_div_d = pwm_div_q + 6'h01;
                            flip = pwm_div_q == 6'h3F;
                        end
                    end else if (half_tick) begin
                        // Half-unit steps, so one period is the register value in whole units
                        half_cnt_d = half_cnt_q + 8'h01;
                        if (half_cnt_d >= {1'b0, ol_period_q}) begin
                            half_cnt_d = 8'h00;
                            flip = 1'b1;
                        end
                    end
                end
                default: begin
                    loop_d = LOOP_IDLE;
                end
            endcase
        end
        pol_d = flip ? ~pol_q : pol_q;
        if (play_q && !play_prev_q) pol_d = emf_ok ? emf_pol : 1'b0;
        sample_d = flip && (dbl_sample || pol_d);
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            loop_q <= LOOP_IDLE;
            half_cnt_q <= 8'h00;
            miss_q <= 2'b00;
            pwm_div_q <= 6'h00;
            boost_q <= 4'h0;
            res_period_q <= 8'h00;
            pol_q <= 1'b0;
            play_prev_q <= 1'b0;
            sample_q <= 1'b0;
        end else begin
            loop_q <= loop_d;
            half_cnt_q <= half_cnt_d;
            miss_q <= miss_d;
            pwm_div_q <= pwm_div_d;
            boost_q <= boost_d;
            res_period_q <= res_period_d;
            pol_q <= pol_d;
            play_prev_q <= play_q;
            sample_q <= sample_d;
        end
    end

    // Calibration and diagnostics
    logic [9:0] cal_len;
    logic cal_bad, diag_bad;
    assign cal_len = {`HSLC_CAL_BASE_UNITS, 2'b00} >> (2'h3 - cal_time);
    assign diag_bad = impedance_code_i >= `HSLC_IMP_OPEN || impedance_code_i < `HSLC_IMP_SHORT;
    assign cal_bad = diag_bad || emf_magnitude_i == 8'h00;
    always_comb begin
        cal_d = cal_q;
        cal_cnt_d = cal_cnt_q;
        cal_comp_d = cal_comp_q;
        cal_emf_d = cal_emf_q;
        // A new fault outranks a clear by the same start command
        diag_fail_d = (cmd_start != 2'b00) ? 1'b0 : diag_fail_q;
        unique case (cal_q)
            CAL_IDLE: begin
                cal_cnt_d = 10'h000;
                if (cmd_start[0]) cal_d = CAL_RUN;
                else if (cmd_start[1]) cal_d = CAL_DIAG;
            end
            CAL_RUN: begin
                if (half_tick) cal_cnt_d = cal_cnt_q + 10'h001;
                if (cal_cnt_q >= cal_len) begin
                    cal_d = CAL_IDLE;
                    cal_comp_d = impedance_code_i;
                    cal_emf_d = emf_magnitude_i;
                    if (cal_bad) diag_fail_d = 1'b1;
                end
            end
            CAL_DIAG: begin
                if (half_tick) cal_cnt_d = cal_cnt_q + 10'h001;
                if (cal_cnt_q >= 10'h004) begin
                    cal_d = CAL_IDLE;
                    if (diag_bad) diag_fail_d = 1'b1;
                end
            end
            default: cal_d = CAL_IDLE;
        endcase
    end
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cal_q <= CAL_IDLE;
            cal_cnt_q <= 10'h000;
            cal_comp_q <= 8'h00;
            cal_emf_q <= 8'h00;
            diag_fail_q <= 1'b0;
        end else begin
            cal_q <= cal_d;
            cal_cnt_q <= cal_cnt_d;
            cal_comp_q <= cal_comp_d;
            cal_emf_q <= cal_emf_d;
            diag_fail_q <= diag_fail_d;
        end
    end

    // Drive level and gain
    logic [15:0] scaled;
    logic [10:0] gain_w;
    logic [7:0] level_d2, gain_d, level_q2, gain_q;
    logic [2:0] emf_eff_d, emf_eff_q;
    logic closed;
    assign closed = loop_q != LOOP_LATCHED;
    always_comb begin
        scaled = input_level_i * rated;
        level_d2 = scaled[15:8] + {7'h00, scaled[7]};
        gain_w = {9'h000, loop_gain} + 11'h001;
        if (boost_en && boost_q != 4'h0) gain_w = gain_w << 1;
        if (closed && brake_i) begin
            gain_w = gain_w * ({8'h00, brake_ratio} + 11'h001);
            // Small input means the brake has almost stopped the actuator
            if (stab_en && input_level_i < 8'h20) gain_w = gain_w >> 1;
        end
        gain_d = (gain_w > 11'h0FF) ? 8'hFF : gain_w[7:0];
        // Overdrive and brake run at the clamp, never beyond it
        if (closed && (brake_i || (boost_q != 4'h0 && play_q))) level_d2 = od_clamp;
        if (level_d2 > od_clamp) level_d2 = od_clamp;
        if (!play_q) level_d2 = 8'h00;
        emf_eff_d = {1'b0, feedback_q[`HSLC_FB_EMF_GAIN_LSB+:2]} + {1'b0, sample_time};
    end
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            level_q2 <= 8'h00;
            gain_q <= 8'h00;
            emf_eff_q <= 3'h0;
        end else begin
            level_q2 <= level_d2;
            gain_q <= gain_d;
            emf_eff_q <= emf_eff_d;
        end
    end

    assign drive_level_o = level_q2;
    assign loop_gain_o = gain_q;
    assign emf_gain_eff_o = emf_eff_q;
    assign emf_sample_o = sample_q;
    assign drive_polarity_o = pol_q;
    assign open_loop_o = loop_q == LOOP_LATCHED || loop_q == LOOP_OPEN;
endmodule

// [tb/hslc_loop_ctrl_checker.sv]
/*
 Port checker for the haptic loop control block.
 Assumes it is bound to hslc_loop_ctrl and sees only its ports.
*/
module hslc_loop_ctrl_checker (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] drive_level_o,
    input wire logic [7:0] loop_gain_o,
    input wire logic [2:0] emf_gain_eff_o,
    input wire logic emf_sample_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack_next;
        s_req |=> s_ack_once;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
    property p_ack_cause;
        $rose(wb_ack_o) |-> $past(wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_hold;
        !$past(wb_stb_i) |-> $stable(wb_dat_o);
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved while idle");
    property p_unmapped;
        s_req and (!wb_we_i && wb_adr_i == 8'h03) |=> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_status_hi;
        s_req and (!wb_we_i && wb_adr_i == 8'h00) |=> wb_dat_o[31:6] == 26'h0;
    endproperty
    a_status_hi: assert property (p_status_hi) else $error("status upper bits set");
    property p_sample_pulse;
        emf_sample_o |=> !emf_sample_o;
    endproperty
    a_sample_pulse: assert property (p_sample_pulse) else $error("sample strobe too long");
    property p_gain_range;
        emf_gain_eff_o <= 3'h6;
    endproperty
    a_gain_range: assert property (p_gain_range) else $error("effective gain out of range");
    property p_reset_out;
        $rose(reset_n_i) |-> !wb_ack_o && drive_level_o == 8'h00 && loop_gain_o == 8'h00;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
endmodule

// [tb/hslc_actuator_model.sv]
/*
 Linear actuator model: motion shows as back-EMF zero crosses.
 Assumes the bench steps it from the system clock.
*/
module hslc_actuator_model (
    input wire logic clk_sys_i,
    input wire logic run_i,
    input wire logic [7:0] half_i,
    output logic zero_cross_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q = 8'h00;
    initial zero_cross_o = 1'b0;
    // A stalled actuator gives no crosses at all
    always @(posedge clk_sys_i) begin
        if (run_i && cnt_q + 8'h01 >= half_i) begin
            zero_cross_o <= ~zero_cross_o;
            cnt_q <= 8'h00;
        end else if (run_i) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

// [tb/hslc_loop_ctrl_tb_top.sv]
/*
 Register-level bench of the haptic loop control block.
 Assumes OL_HALF_CYC of 8 and the actuator model beside it.
*/
module hslc_loop_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0, reset_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, input_level_i = 8'hFF, impedance_code_i = 8'h40, emf_magnitude_i = 8'h80;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic emf_valid_i = 1'b0, emf_polarity_i = 1'b0, pwm_in_i = 1'b0, brake_i = 1'b0, run = 1'b0;
    logic pwm_en = 1'b0, emf_zero_cross_i, wb_ack_o, drive_polarity_o, emf_sample_o, open_loop_o, pol_prev;
    logic [7:0] drive_level_o, loop_gain_o;
    logic [2:0] emf_gain_eff_o;
    int n_fail = 0, checked = 0, flips = 0, samples = 0, gap_cnt = 0, last_gap = 0;
    hslc_loop_ctrl #(.OL_HALF_CYC(8)) uut (.*);
    hslc_actuator_model act (.clk_sys_i(clk_sys_i), .run_i(run), .half_i(8'h50), .zero_cross_o(emf_zero_cross_i));
    always #10 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (pwm_en) pwm_in_i <= ~pwm_in_i;
    always @(posedge clk_sys_i) begin
        gap_cnt++;
        if (drive_polarity_o !== pol_prev) begin
            flips++;
            last_gap = gap_cnt;
            gap_cnt = 0;
        end
        if (emf_sample_o === 1'b1) samples++;
        pol_prev = drive_polarity_o;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            test_done();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic st(input logic [1:0] s);
        wb(1'b0, 8'h00, 32'h0);
        chk(32'(q[3:2]), 32'(s));
    endtask
    task automatic win(input int n, input int ef, input int es);
        @(negedge clk_sys_i);
        flips = 0;
        samples = 0;
        repeat (n) @(negedge clk_sys_i);
        chk(32'(flips), 32'(ef));
        chk(32'(samples), 32'(es));
    endtask
    task automatic rst(input int n);
        reset_n_i <= 1'b0;
        cyc(n);
        reset_n_i <= 1'b1;
    endtask
    task automatic run_cmd(input logic [31:0] c, input logic [31:0] flag);
        int n;
        wb(1'b1, 8'h0C, c);
        n = 0;
        do begin
            cyc(8);
            wb(1'b0, 8'h00, 32'h0);
            n++;
        end while (q[4] !== 1'b0 && n < 100);
        if (n >= 100) begin
            n_fail++;
            test_done();
        end
        chk(32'(q[0]), flag);
    endtask
    initial begin
        rst(12);
        rd(8'h1A, 32'h36);
        rd(8'h1B, 32'h05022);
        rd(8'h1C, 32'hFF3E);
        rd(8'h1F, 32'h0);
        rd(8'h20, 32'h33);
        wb(1'b1, 8'h03, 32'hFF);
        rd(8'h03, 32'h0);
        emf_valid_i <= 1'b1;
        emf_polarity_i <= 1'b1;
        wb(1'b1, 8'h1A, 32'hB6);
        wb(1'b1, 8'h1B, 32'h05023);
        wb(1'b1, 8'h0C, 32'h1);
        cyc(3);
        chk(32'(drive_polarity_o), 32'h1);
        chk(32'(loop_gain_o), 32'h4);
        wb(1'b1, 8'h0C, 32'h0);
        emf_valid_i <= 1'b0;
        wb(1'b1, 8'h0C, 32'h1);
        cyc(3);
        chk(32'(drive_polarity_o), 32'h0);
        emf_valid_i <= 1'b1;
        run <= 1'b1;
        cyc(600);
        rd(8'h22, 32'h0A);
        st(2'd1);
        chk(32'(loop_gain_o), 32'h2);
        chk(32'(drive_level_o), 32'h3E);
        chk(32'(emf_gain_eff_o), 32'h2);
        win(800, 10, 5);
        wb(1'b1, 8'h1B, 32'h05027);
        win(800, 10, 10);
        brake_i <= 1'b1;
        cyc(4);
        chk(32'(loop_gain_o), 32'h8);
        chk(32'(drive_level_o), 32'hFF);
        input_level_i <= 8'h10;
        cyc(4);
        chk(32'(loop_gain_o), 32'h4);
        brake_i <= 1'b0;
        input_level_i <= 8'hFF;
        run <= 1'b0;
        emf_valid_i <= 1'b0;
        cyc(400);
        st(2'd2);
        chk(32'(open_loop_o), 32'h1);
        chk(32'(last_gap), 32'h98);
        emf_valid_i <= 1'b1;
        run <= 1'b1;
        cyc(200);
        st(2'd1);
        chk(32'(open_loop_o), 32'h0);
        wb(1'b1, 8'h1F, 32'h24);
        run <= 1'b0;
        cyc(200);
        st(2'd1);
        cyc(250);
        st(2'd3);
        run <= 1'b1;
        cyc(300);
        st(2'd3);
        wb(1'b1, 8'h20, 32'h5);
        cyc(300);
        chk(32'(last_gap), 32'h28);
        rst(3);
        wb(1'b1, 8'h1A, 32'hB6);
        wb(1'b1, 8'h1B, 32'h0503A);
        pwm_en <= 1'b1;
        wb(1'b1, 8'h0C, 32'h1);
        cyc(700);
        chk(32'(last_gap), 32'h80);
        pwm_en <= 1'b0;
        rst(3);
        impedance_code_i <= 8'hF8;
        run_cmd(32'h4, 32'h1);
        impedance_code_i <= 8'h40;
        run_cmd(32'h4, 32'h0);
        run_cmd(32'h2, 32'h0);
        rd(8'h1A, 32'h35);
        rd(8'h18, 32'h40);
        rd(8'h19, 32'h80);
        emf_magnitude_i <= 8'h00;
        run_cmd(32'h2, 32'h1);
        test_done();
    end
endmodule
bind hslc_loop_ctrl hslc_loop_ctrl_checker u_chk (.*);
